// ---- include/nvw_cfg.svh ----
/*
 file: constants of the non-volatile write guard (offsets, fields, codes, timing)
 assumes: included by the design files, 200 MHz core clock
*/
// How it works
// R1 - lock/ID block of page 48 stays readable
// R2 - master never writes ID bytes 22..31
// R3 - locked: ID bytes read only
// R4 - blocks 0..2 of page 48 denied when locked
// R5 - bad byte: withhold next acknowledge
// R6 - status read returns error code byte
// R7 - master restarts entry after status or error
// R8 - status bit 7 is lock, low bits code
// R9 - forbidden-when-locked command reports not-allowed
// R10 - unknown command reports wrong-command
// R11 - nonzero entry mode code reports wrong-mode
// R12 - nonexistent location write raises no error
// R13 - byte and block write take 4.5 ms
// R14 - core stalled; interrupt aborts the write
// R15 - byte write: page from select, address from store
// R16 - block data from register file 0..31
// R17 - block write: page, block, all 32 bytes
// R18 - protect pages from first up to unprotected
// R19 - protected page write aborts, sets flag
// R20 - equal option bytes protect nothing
// R21 - programming mode ignores page protection
// R22 - status register is input 40, reset zero
// R23 - bit 0 abort; flags cleared on success
// R24 - lock sampled at programming entry
`ifndef NVW_CFG_SVH
`define NVW_CFG_SVH
`define NVW_OPT_FIRST_PROT 8'h05
`define NVW_OPT_FIRST_UNPROT 8'h06
`define NVW_IN_STATUS 8'h28
`define NVW_STATUS_RESET 8'h00
`define NVW_ST_ABORT_BIT 0
`define NVW_ST_PROT_BIT 1
`define NVW_ID_PAGE 8'h30
`define NVW_ID_BLOCK 3'h3
`define NVW_ID_LAST_USER 5'h15
`define NVW_LOCK_VALUE 8'hff
`define NVW_ERR_NONE 7'h00
`define NVW_ERR_WRONG_CMD 7'h05
`define NVW_ERR_NOT_ALLOWED 7'h06
`define NVW_ERR_WRONG_MODE 7'h10
`define NVW_MODE_CODE 8'h00
`define NVW_BLOCK_BYTES 32
`define NVW_WRITE_TIME_NS 4500000
`define NVW_CLK_PERIOD_NS 5
`define NVW_WRITE_CYCLES (`NVW_WRITE_TIME_NS / `NVW_CLK_PERIOD_NS)
`endif

// ---- include/nvw_pkg.sv ----
/*
 file: types of the non-volatile write guard
 assumes: nvw_cfg.svh is on the include path
*/
package nvw_pkg;
	typedef enum logic [1:0]
	{
		NVW_IDLE = 2'b00,
		NVW_PROG = 2'b01,
		NVW_DONE = 2'b11
	} nvw_state_t;
	typedef enum logic [2:0]
	{
		NVW_CMD_NONE = 3'h0,
		NVW_CMD_WRITE = 3'h1,
		NVW_CMD_READ = 3'h2,
		NVW_CMD_STATUS = 3'h3,
		NVW_CMD_ERASE = 3'h4,
		NVW_CMD_OTHER = 3'h5,
		NVW_CMD_BAD = 3'h7
	} nvw_cmd_t;
endpackage

// ---- rtl/nvw_guard.sv ----
/*
 file: write guard for the non-volatile memory; core byte/block writes with page
 protection, programming-session access checks, error status byte.
 assumes: the core decodes instructions and the serial engine decodes bytes;
 this block decides, times the write and reports. single 200 MHz clock.
*/
`timescale 1ns/1ps
`include "nvw_cfg.svh"
module nvw_guard
	import nvw_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `NVW_WRITE_CYCLES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// option bytes
	input wire logic [7:0] first_protected_page_i,
	input wire logic [7:0] first_unprotected_page_i,
	// core side
	input wire logic page_select_i,
	input wire logic [7:0] page_value_i,
	input wire logic nv_store_i,
	input wire logic [7:0] byte_addr_i,
	input wire logic [7:0] store_data_i,
	input wire logic block_write_i,
	input wire logic [2:0] block_arg_i,
	input wire logic irq_req_i,
	input wire logic [7:0] in_reg_addr_i,
	output logic [7:0] in_reg_data_o,
	output logic core_stall_o,
	// register file read port for block data
	output logic [4:0] rf_addr_o,
	input wire logic [7:0] rf_data_i,
	// memory array write port
	output logic mem_we_o,
	output logic [7:0] mem_page_o,
	output logic [7:0] mem_addr_o,
	output logic [7:0] mem_data_o,
	output logic mem_block_o,
	// programming session side
	input wire logic prog_enter_i,
	input wire logic [7:0] prog_mode_i,
	input wire logic [7:0] lock_byte_i,
	input wire logic prog_exit_i,
	input wire logic byte_valid_i,
	input wire nvw_cmd_t cmd_i,
	input wire logic [7:0] acc_page_i,
	input wire logic [7:0] acc_addr_i,
	output logic ack_o,
	output logic access_ok_o,
	output logic [7:0] status_byte_o,
	output logic locked_o
);
	typedef struct packed
	{
		nvw_state_t st;
		logic stall;
		logic [31:0] cnt;
		logic [7:0] page;
		logic [7:0] addr;
		logic [7:0] data;
		logic blk;
		logic [4:0] idx;
		logic aborted;
		logic prot;
		logic [7:0] in_data;
		logic we;
		logic [7:0] mp;
		logic [7:0] ma;
		logic [7:0] md;
		logic session;
		logic locked;
		logic err_pend;
		logic [6:0] err_code;
		logic ack;
		logic acc_ok;
		logic [7:0] status;
	} nvw_regs_t;

	nvw_regs_t r;
	nvw_regs_t nxt;
	logic page_protected;
	logic [2:0] acc_blk;
	logic id_block;
	logic lock_blocks;
	logic acc_deny;

	// protected range, empty when equal; wraps if start above end
	// R18 range compare
	always_comb
	begin
		page_protected = 1'b0;
		if (first_protected_page_i == first_unprotected_page_i)
			page_protected = 1'b0;
		else if (first_protected_page_i < first_unprotected_page_i)
			page_protected = (r.page >= first_protected_page_i) && (r.page < first_unprotected_page_i);
		else
			page_protected = (r.page >= first_protected_page_i) || (r.page < first_unprotected_page_i);
	end

	// R1 R4 page 48 block split
	assign acc_blk = acc_addr_i[7:5];
	assign id_block = (acc_page_i == `NVW_ID_PAGE) && (acc_blk == `NVW_ID_BLOCK);
	assign lock_blocks = (acc_page_i == `NVW_ID_PAGE) && (acc_blk != `NVW_ID_BLOCK);
	// R3 R4 R9 locked session: only id block reads, status, erase
	always_comb
	begin
		acc_deny = 1'b0;
		if (r.locked)
		begin
			case (cmd_i)
				NVW_CMD_READ: acc_deny = !id_block;
				NVW_CMD_STATUS: acc_deny = 1'b0;
				NVW_CMD_ERASE: acc_deny = 1'b0;
				default: acc_deny = 1'b1;
			endcase
		end
		if (lock_blocks && r.locked)
			acc_deny = 1'b1;
	end

	always_comb
	begin
		nxt = r;
		nxt.we = 1'b0;
		nxt.ack = 1'b0;
		nxt.acc_ok = 1'b0;
		if (page_select_i && r.st == NVW_IDLE)
			nxt.page = page_value_i;
		case (r.st)
			NVW_IDLE:
			begin
				// R15 byte write starts at once
				if (nv_store_i)
				begin
					nxt.addr = byte_addr_i;
					nxt.data = store_data_i;
					nxt.blk = 1'b0;
					nxt.idx = 5'h00;
					nxt.cnt = 32'h0;
					nxt.st = NVW_PROG;
				end
				// R17 block write address
				else if (block_write_i)
				begin
					nxt.addr = {block_arg_i, 5'h00};
					nxt.blk = 1'b1;
					nxt.idx = 5'h00;
					nxt.cnt = 32'h0;
					nxt.st = NVW_PROG;
				end
				// R19 protected page aborts
				if ((nv_store_i || block_write_i) && page_protected)
				begin
					nxt.prot = 1'b1;
					nxt.st = NVW_IDLE;
				end
			end
			NVW_PROG:
			begin
				// R16 R17 block load of all 32 bytes, one byte per cycle
				if (r.blk && r.cnt < 32'(`NVW_BLOCK_BYTES))
				begin
					nxt.we = 1'b1;
					nxt.mp = r.page;
					nxt.ma = {r.addr[7:5], r.idx};
					nxt.md = rf_data_i;
					nxt.idx = r.idx + 5'h01;
				end
				else if (!r.blk && r.cnt == 32'h0)
				begin
					nxt.we = 1'b1;
					nxt.mp = r.page;
					nxt.ma = r.addr;
					nxt.md = r.data;
				end
				nxt.cnt = r.cnt + 32'h1;
				// R14 interrupt aborts
				if (irq_req_i)
				begin
					nxt.aborted = 1'b1;
					nxt.st = NVW_IDLE;
				end
				// R13 fixed write time
				else if (r.cnt == WRITE_CYCLES - 1)
					nxt.st = NVW_DONE;
			end
			NVW_DONE:
			begin
				// R23 success clears both flags
				nxt.aborted = 1'b0;
				nxt.prot = 1'b0;
				nxt.st = NVW_IDLE;
			end
			default: nxt.st = NVW_IDLE;
		endcase
		nxt.stall = (nxt.st != NVW_IDLE);
		// R22 input register 40
		nxt.in_data = 8'h00;
		if (in_reg_addr_i == `NVW_IN_STATUS)
		begin
			nxt.in_data[`NVW_ST_ABORT_BIT] = nxt.aborted;
			nxt.in_data[`NVW_ST_PROT_BIT] = nxt.prot;
		end
		// R24 lock sampled at entry
		if (prog_enter_i)
		begin
			nxt.session = 1'b1;
			nxt.locked = (lock_byte_i == `NVW_LOCK_VALUE);
			nxt.err_pend = 1'b0;
			nxt.err_code = `NVW_ERR_NONE;
			// R11 wrong mode
			if (prog_mode_i != `NVW_MODE_CODE)
			begin
				nxt.err_pend = 1'b1;
				nxt.err_code = `NVW_ERR_WRONG_MODE;
			end
		end
		else if (prog_exit_i)
			nxt.session = 1'b0;
		else if (byte_valid_i && r.session)
		begin
			// R5 ack withheld once error stands
			nxt.ack = !r.err_pend;
			if (cmd_i == NVW_CMD_STATUS)
				nxt.ack = 1'b1;
			// R10 unknown command
			if (cmd_i == NVW_CMD_BAD)
			begin
				nxt.err_pend = 1'b1;
				nxt.err_code = `NVW_ERR_WRONG_CMD;
			end
			// R9 R3 R4 not allowed while locked
			else if (acc_deny)
			begin
				nxt.err_pend = 1'b1;
				nxt.err_code = `NVW_ERR_NOT_ALLOWED;
			end
			// R21 R12 no page protection, no address check
			else
				nxt.acc_ok = (cmd_i != NVW_CMD_NONE);
		end
		// R6 R8 status byte
		nxt.status = {nxt.locked, nxt.err_code};
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			r <= '0;
			r.st <= NVW_IDLE;
			r.in_data <= `NVW_STATUS_RESET;
		end
		else
			r <= nxt;
	end

	// R14 core held while programming
	assign core_stall_o = r.stall;
	assign rf_addr_o = r.idx;
	assign in_reg_data_o = r.in_data;
	assign mem_we_o = r.we;
	assign mem_page_o = r.mp;
	assign mem_addr_o = r.ma;
	assign mem_data_o = r.md;
	assign mem_block_o = r.blk;
	assign ack_o = r.ack;
	assign access_ok_o = r.acc_ok;
	assign status_byte_o = r.status;
	assign locked_o = r.locked;

	sequence start_write_s;
		r.st == NVW_IDLE && (nv_store_i || block_write_i) && !page_protected;
	endsequence

	// R15
	store_starts_a: assert property (@(posedge clk_i) disable iff (srst_i) // R15 R14
		start_write_s |=> r.st == NVW_PROG && core_stall_o)
		else $error("write did not start");
	prot_sets_flag_a: assert property (@(posedge clk_i) disable iff (srst_i) // R19
		r.st == NVW_IDLE && (nv_store_i || block_write_i) && page_protected |=> r.prot && !core_stall_o)
		else $error("protected write not refused");
	irq_abort_a: assert property (@(posedge clk_i) disable iff (srst_i) // R14
		r.st == NVW_PROG && irq_req_i |=> r.aborted && r.st == NVW_IDLE)
		else $error("interrupt did not abort");
	success_clear_a: assert property (@(posedge clk_i) disable iff (srst_i) // R23
		r.st == NVW_DONE |=> !r.aborted && !r.prot)
		else $error("flags kept after success");
	equal_no_prot_a: assert property (@(posedge clk_i) disable iff (srst_i) // R20
		first_protected_page_i == first_unprotected_page_i |-> !page_protected)
		else $error("equal bytes protect");
	status_lock_a: assert property (@(posedge clk_i) disable iff (srst_i) // R8
		status_byte_o[7] == locked_o)
		else $error("status msb not lock");
	// R24 lock taken at entry
	lock_entry_a: assert property (@(posedge clk_i) disable iff (srst_i) // R24
		prog_enter_i && lock_byte_i == `NVW_LOCK_VALUE |=> locked_o && status_byte_o[7])
		else $error("lock not sampled at entry");
	mode_err_a: assert property (@(posedge clk_i) disable iff (srst_i) // R11
		prog_enter_i && prog_mode_i != 8'h00 |=> status_byte_o[6:0] == 7'h10)
		else $error("wrong mode not reported");
	bad_cmd_a: assert property (@(posedge clk_i) disable iff (srst_i) // R10
		r.session && !prog_enter_i && !prog_exit_i && byte_valid_i && cmd_i == NVW_CMD_BAD
		|=> status_byte_o[6:0] == 7'h05)
		else $error("wrong command not reported");
	locked_write_a: assert property (@(posedge clk_i) disable iff (srst_i) // R9
		r.session && r.locked && !prog_enter_i && !prog_exit_i && byte_valid_i && cmd_i == NVW_CMD_WRITE
		|=> !access_ok_o && status_byte_o[6:0] == 7'h06)
		else $error("locked write allowed");
	err_nack_a: assert property (@(posedge clk_i) disable iff (srst_i) // R5
		r.err_pend && r.session && !prog_enter_i && !prog_exit_i && byte_valid_i && cmd_i != NVW_CMD_STATUS
		|=> !ack_o)
		else $error("ack after error");
endmodule

// ---- sim/nvw_rf_model.sv ----
/*
 register file model: returns block write data for an index
 assumes: same-cycle read, index driven by the guard
*/
`timescale 1ns/1ps
module nvw_rf_model
(
	// index in, data out
	input wire logic [4:0] rf_addr_i,
	output logic [7:0] rf_data_o
);
	// locations 0..31 hold the block data
	assign rf_data_o = {3'h5, rf_addr_i} ^ 8'h3c;
endmodule

// ---- sim/tb.sv ----
/*
 bench for the write guard: core writes, protection, status, session checks
 assumes: guard with short write time, register file model beside it
*/
`timescale 1ns/1ps
module tb;
	import nvw_pkg::*;
	logic clk_i = 0, srst_i = 1, ps = 0, st = 0, bw = 0, irq = 0, pe = 0, px = 0, bv = 0;
	logic ack, ok, stall, we, blk, lk;
	logic [7:0] fp = 8'h05, fu = 8'h06, pv = 0, ba = 0, sd = 8'ha7, ra = 8'h28, rd, pm = 0, lb = 0;
	logic [7:0] ap = 0, aa = 0, mp, ma, md, sb, rf, v;
	logic [4:0] rx;
	logic [2:0] barg = 0;
	nvw_cmd_t cmd = NVW_CMD_NONE;
	int err_total = 0, checked = 0;
	initial forever #2.5 clk_i = ~clk_i;
	nvw_rf_model rfm (.rf_addr_i(rx), .rf_data_o(rf));
	nvw_guard #(.WRITE_CYCLES(40)) uut (.clk_i(clk_i), .srst_i(srst_i), .first_protected_page_i(fp),
		.first_unprotected_page_i(fu), .page_select_i(ps), .page_value_i(pv), .nv_store_i(st),
		.byte_addr_i(ba), .store_data_i(sd), .block_write_i(bw), .block_arg_i(barg), .irq_req_i(irq),
		.in_reg_addr_i(ra), .in_reg_data_o(rd), .core_stall_o(stall), .rf_addr_o(rx), .rf_data_i(rf),
		.mem_we_o(we), .mem_page_o(mp), .mem_addr_o(ma), .mem_data_o(md), .mem_block_o(blk),
		.prog_enter_i(pe), .prog_mode_i(pm), .lock_byte_i(lb), .prog_exit_i(px), .byte_valid_i(bv),
		.cmd_i(cmd), .acc_page_i(ap), .acc_addr_i(aa), .ack_o(ack), .access_ok_o(ok),
		.status_byte_o(sb), .locked_o(lk));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic status(input logic [7:0] exp);
		tick(1);
		chk(rd, exp);
	endtask
	// page select then store or block start
	task automatic run(input logic [7:0] pg, input logic [7:0] ad, input logic bk, input int n);
		int k;
		k = 0;
		pv = pg;
		ps = 1;
		tick(1);
		ps = 0;
		ba = ad;
		barg = ad[2:0];
		st = !bk;
		bw = bk;
		tick(1);
		st = 0;
		bw = 0;
		for (int i = 0; i < 120; i++)
		begin
			tick(1);
			if (we === 1'b1)
			begin
				chk(mp, pg);
				chk(ma, bk ? {ad[2:0], 5'h00} + 8'(k) : ad);
				chk(md, bk ? {3'h5, k[4:0]} ^ 8'h3c : sd);
				chk({7'h00, blk}, {7'h00, bk});
				k++;
			end
			if (i > 2 && stall === 1'b0)
				break;
			if (i == 119)
			begin
				chk({7'h00, stall}, 8'h00);
				end_of_test();
			end
		end
		chk(8'(k), 8'(n));
		$display("core write page %h done", pg);
	endtask
	task automatic enter(input logic [7:0] m, input logic [7:0] l);
		px = 1;
		tick(1);
		px = 0;
		pm = m;
		lb = l;
		pe = 1;
		tick(1);
		pe = 0;
		tick(1);
	endtask
	task automatic sbyte(input nvw_cmd_t c, input logic [7:0] p, input logic [7:0] a);
		cmd = c;
		ap = p;
		aa = a;
		bv = 1;
		tick(1);
		bv = 0;
		v = {6'h00, ack, ok};
		tick(1);
		v = v | {6'h00, ack, ok};
	endtask
	initial
	begin
		tick(8);
		srst_i = 0;
		status(8'h00);
		run(8'h05, 8'h10, 0, 0);
		status(8'h02);
		ra = 8'h27;
		status(8'h00);
		ra = 8'h28;
		run(8'h06, 8'h21, 0, 1);
		status(8'h00);
		pv = 8'h07;
		ps = 1;
		tick(1);
		ps = 0;
		st = 1;
		tick(1);
		st = 0;
		tick(3);
		irq = 1;
		tick(1);
		irq = 0;
		tick(3);
		chk({7'h00, stall}, 8'h00);
		status(8'h01);
		run(8'h09, 8'h02, 1, 32);
		status(8'h00);
		fu = 8'h05;
		run(8'h05, 8'h03, 0, 1);
		fu = 8'h06;
		$display("core tests done");
		enter(8'h00, 8'h00);
		sbyte(NVW_CMD_WRITE, 8'h05, 8'h00);
		chk(v, 8'h03);
		lb = 8'hff;
		sbyte(NVW_CMD_WRITE, 8'hf0, 8'h00);
		chk(v, 8'h03);
		sbyte(NVW_CMD_BAD, 8'h01, 8'h00);
		sbyte(NVW_CMD_READ, 8'h01, 8'h00);
		chk({7'h00, v[1]}, 8'h00);
		sbyte(NVW_CMD_STATUS, 8'h00, 8'h00);
		chk(sb, 8'h05);
		enter(8'h01, 8'h00);
		sbyte(NVW_CMD_STATUS, 8'h00, 8'h00);
		chk(sb, 8'h10);
		enter(8'h00, 8'hff);
		chk({7'h00, lk}, 8'h01);
		sbyte(NVW_CMD_WRITE, 8'h01, 8'h00);
		chk({7'h00, v[0]}, 8'h00);
		sbyte(NVW_CMD_STATUS, 8'h00, 8'h00);
		chk(sb, 8'h86);
		enter(8'h00, 8'hff);
		sbyte(NVW_CMD_READ, 8'h30, 8'h65);
		chk({7'h00, v[0]}, 8'h01);
		enter(8'h00, 8'hff);
		sbyte(NVW_CMD_WRITE, 8'h30, 8'h61);
		chk({7'h00, v[0]}, 8'h00);
		enter(8'h00, 8'hff);
		sbyte(NVW_CMD_READ, 8'h30, 8'h05);
		chk({7'h00, v[0]}, 8'h00);
		$display("session tests done");
		end_of_test();
	end
endmodule
